/* rtl/ppc_pkg.sv */
// Constants and carrier types for the port pin configuration block
// How it works
// - Per-pin bit makes output driver open-drain
// - Analog select resets to all ones
// - Output driven even while analog selected
// - Port read is zero on analog inputs
// - Digital inputs never feed analog conversion
package ppc_pkg;
  localparam int PIN_W = 16;
  localparam int ADDR_W = 3;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_DIR = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_PORT = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_LAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_ODC = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_ANS = 3'h4;
  // Reset values
  localparam logic [PIN_W-1:0] RST_DIR = 16'hFFFF;
  localparam logic [PIN_W-1:0] RST_LAT = 16'h0000;
  localparam logic [PIN_W-1:0] RST_ODC = 16'h0000;
  localparam logic [PIN_W-1:0] RST_ANS = 16'hFFFF;
  // Pin-side bundle
  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe;
  } ppc_pin_drv_t;
  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PIN_W-1:0] wdata;
    logic wr;
    logic rd;
  } ppc_bus_req_t;
endpackage

/* rtl/ppc_sync.sv */
// Two-flop synchroniser for the pin inputs
`timescale 1ns/10ps
module ppc_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  // Register stages
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule // ppc_sync

/* rtl/ppc_port.sv */
// Port pin analog and digital configuration block
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
module ppc_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ppc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ppc_pkg::PIN_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ppc_pkg::PIN_W-1:0] rdata_o,
  // Pins
  input wire logic [ppc_pkg::PIN_W-1:0] pin_i,
  output logic [ppc_pkg::PIN_W-1:0] pin_o,
  output logic [ppc_pkg::PIN_W-1:0] pin_oe_o,
  // Analog peripheral side
  output logic [ppc_pkg::PIN_W-1:0] analog_en_o,
  output logic [ppc_pkg::PIN_W-1:0] digital_in_o
);
  localparam int W = ppc_pkg::PIN_W;
  ppc_pkg::ppc_bus_req_t req;
  ppc_pkg::ppc_pin_drv_t drv;
  logic [W-1:0] dir_q, dir_d;
  logic [W-1:0] lat_q, lat_d;
  logic [W-1:0] odc_q, odc_d;
  logic [W-1:0] ans_q, ans_d;
  logic [W-1:0] rdata_q, rdata_d;
  logic [W-1:0] pin_sync;
  logic [W-1:0] port_val;

  // Bundle the bus request
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  ppc_sync #(
    .W(W)
  ) i_ppc_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_i),
    .q_o(pin_sync)
  );

  // Control register writes
  always_comb begin
    dir_d = dir_q;
    lat_d = lat_q;
    odc_d = odc_q;
    ans_d = ans_q;
    if (req.wr) begin
      case (req.addr)
        ppc_pkg::OFS_DIR: dir_d = req.wdata;
        ppc_pkg::OFS_PORT, ppc_pkg::OFS_LAT: lat_d = req.wdata;
        ppc_pkg::OFS_ODC: odc_d = req.wdata;
        ppc_pkg::OFS_ANS: ans_d = req.wdata;
        default: ;
      endcase
    end
  end

  // Register the controls
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q <= ppc_pkg::RST_DIR;
      lat_q <= ppc_pkg::RST_LAT;
      odc_q <= ppc_pkg::RST_ODC;
      ans_q <= ppc_pkg::RST_ANS;
    end else begin
      dir_q <= dir_d;
      lat_q <= lat_d;
      odc_q <= odc_d;
      ans_q <= ans_d;
    end
  end

  assign port_val = pin_sync & ~(ans_q & dir_q);

  // Read data mux, valid one cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      case (req.addr)
        ppc_pkg::OFS_DIR: rdata_d = dir_q;
        ppc_pkg::OFS_PORT: rdata_d = port_val;
        ppc_pkg::OFS_LAT: rdata_d = lat_q;
        ppc_pkg::OFS_ODC: rdata_d = odc_q;
        ppc_pkg::OFS_ANS: rdata_d = ans_q;
        default: rdata_d = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pin drivers per bit
  for (genvar i = 0; i < W; i++) begin : g_pin
    // output driven regardless of analog select
    assign drv.out[i] = odc_q[i] ? 1'b0 : lat_q[i];
    assign drv.oe[i] = ~dir_q[i] & (odc_q[i] ? ~lat_q[i] : 1'b1);
  end

  assign rdata_o = rdata_q;
  assign pin_o = drv.out;
  assign pin_oe_o = drv.oe;
  // analog path only for analog-selected pins
  assign analog_en_o = ans_q;
  assign digital_in_o = pin_sync & ~ans_q;

  // Assertions

  // Request, register state and reset history shapes used by the properties below
  sequence s_port_rd;
    rd_i && addr_i == ppc_pkg::OFS_PORT;
  endsequence
  sequence s_dir_rd;
    rd_i && addr_i == ppc_pkg::OFS_DIR;
  endsequence
  // A port write lands in the latch as well
  sequence s_lat_wr;
    wr_i && (addr_i == ppc_pkg::OFS_LAT || addr_i == ppc_pkg::OFS_PORT);
  endsequence
  // Every pin a push-pull output
  sequence s_plain_out;
    dir_q == '0 && odc_q == '0;
  endsequence
  // Synchroniser refilled after reset
  sequence s_out_of_reset;
    !$past(rst_i) && !$past(rst_i, 2);
  endsequence

  a_analog_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_port_rd |=> ((rdata_o & $past(ans_q & dir_q)) == '0))
    else $error("analog input bit read nonzero");

  a_port_read_value: assert property (@(posedge clk_i) disable iff (rst_i)
    s_port_rd |=> rdata_o == ($past(pin_sync) & ~$past(ans_q & dir_q)))
    else $error("port read differs from synced pins");

  a_reset_analog: assert property (@(posedge clk_i) $fell(rst_i) |-> ans_q == ppc_pkg::RST_ANS)
    else $error("analog select not all ones after reset");

  a_reset_defaults: assert property (@(posedge clk_i) $fell(rst_i) |->
    dir_q == ppc_pkg::RST_DIR && lat_q == ppc_pkg::RST_LAT && odc_q == ppc_pkg::RST_ODC && rdata_o == '0)
    else $error("control register not at reset value");

  a_latch_drives: assert property (@(posedge clk_i) disable iff (rst_i)
    s_lat_wr ##1 s_plain_out |-> pin_o == $past(wdata_i) && pin_oe_o == '1)
    else $error("latch value not driven");

  a_dir_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == ppc_pkg::OFS_DIR) |=> dir_q == $past(wdata_i))
    else $error("direction write lost");

  a_analog_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == ppc_pkg::OFS_ANS) |=> ans_q == $past(wdata_i))
    else $error("analog select write lost");

  a_unmapped_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i > ppc_pkg::OFS_ANS) |=>
    $stable(dir_q) && $stable(lat_q) && $stable(odc_q) && $stable(ans_q))
    else $error("unmapped write changed a control");

  a_open_drain_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ((odc_q & pin_o) == '0) && ((odc_q & lat_q & pin_oe_o) == '0))
    else $error("open drain pin driven high");

  a_open_drain_low: assert property (@(posedge clk_i) disable iff (rst_i)
    ((odc_q & ~dir_q & ~lat_q & ~pin_oe_o) == '0))
    else $error("open drain pin not pulled low");

  a_analog_out: assert property (@(posedge clk_i) disable iff (rst_i)
    ((~dir_q & ~odc_q & ~pin_oe_o) == '0))
    else $error("output pin not driven");

  a_analog_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ((ans_q & ~dir_q & ~odc_q & (~pin_oe_o | (pin_o ^ lat_q))) == '0))
    else $error("analog selected output lost its level");

  a_input_released: assert property (@(posedge clk_i) disable iff (rst_i)
    ((dir_q & pin_oe_o) == '0))
    else $error("input pin driven");

  a_digital_no_analog: assert property (@(posedge clk_i) disable iff (rst_i)
    ((analog_en_o & digital_in_o) == '0) && analog_en_o == ans_q)
    else $error("digital input routed to analog");

  a_digital_in_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    s_out_of_reset |-> digital_in_o == ($past(pin_i, 2) & ~ans_q))
    else $error("digital input not the synced pin level");

  a_read_latency: assert property (@(posedge clk_i) disable iff (rst_i)
    s_dir_rd |=> rdata_o == $past(dir_q))
    else $error("read data late");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_i |=> rdata_o == '0)
    else $error("read data not zero without a read");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i > ppc_pkg::OFS_ANS) |=> rdata_o == '0)
    else $error("unmapped read nonzero");
endmodule // ppc_port

/* verif/ppc_board.sv */
// Board model: pull-ups and outside drivers on the pins
`timescale 1ns/10ps
module ppc_board (
  // Device side
  input wire logic [ppc_pkg::PIN_W-1:0] pin_o_i,
  input wire logic [ppc_pkg::PIN_W-1:0] pin_oe_i,
  // Board side
  input wire logic [ppc_pkg::PIN_W-1:0] pu_i,
  input wire logic [ppc_pkg::PIN_W-1:0] ext_i,
  output logic [ppc_pkg::PIN_W-1:0] level_o
);
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & (pu_i | ext_i));
endmodule // ppc_board

/* verif/ppc_port_test.sv */
// Self-checking bench for the port pin configuration block
`timescale 1ns/10ps
module ppc_port_test;
  typedef logic [ppc_pkg::PIN_W-1:0] ppc_w_t;
  logic clk_i = 0;
  logic rst_i = 1;
  logic wr_i = 0;
  logic rd_i = 0;
  logic [ppc_pkg::ADDR_W-1:0] addr_i = '0;
  ppc_w_t wdata_i = '0, rdata_o, pin_i, pin_o, pin_oe_o, analog_en_o, digital_in_o;
  ppc_w_t pu = '0, ext = '0, dir, lat, odc, ans, oe, lvl;
  int miscompares = 0, n_checks = 0;
  ppc_port i_ppc_port (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o,
    .analog_en_o, .digital_in_o);
  ppc_board i_ppc_board (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pu_i(pu), .ext_i(ext), .level_o(pin_i));
  // Clock
  initial forever #5 clk_i = ~clk_i;
  // Expected drive enable and pin level
  function automatic ppc_w_t oe_exp();
    return ~dir & ~(odc & lat);
  endfunction
  function automatic ppc_w_t lvl_exp();
    return (oe & lat) | (~oe & (pu | ext));
  endfunction
  task automatic chk(string nm, ppc_w_t exp, ppc_w_t got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [ppc_pkg::ADDR_W-1:0] a, ppc_w_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [ppc_pkg::ADDR_W-1:0] a, ppc_w_t exp, string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, exp, rdata_o);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    results();
  end
  // Main sequence
  initial begin
    void'($urandom(32'hD69D5FC0));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ppc_pkg::OFS_DIR, 16'hFFFF, "dir");
    rd(ppc_pkg::OFS_PORT, 16'h0000, "port");
    rd(ppc_pkg::OFS_ODC, 16'h0000, "odc");
    rd(ppc_pkg::OFS_ANS, 16'hFFFF, "ans");
    rd(3'h5, 16'h0000, "unmapped");
    chk("pin_oe", 16'h0000, pin_oe_o);
    chk("analog_en", 16'hFFFF, analog_en_o);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      // Passes 2 and 3 make every pin a push-pull output
      dir = i inside {2, 3} ? '0 : 16'($urandom);
      lat = 16'($urandom);
      odc = i == 0 ? '1 : i inside {2, 3} ? '0 : 16'($urandom);
      ans = i == 0 ? '0 : i == 1 ? '1 : 16'($urandom);
      pu <= 16'($urandom);
      ext <= 16'($urandom);
      wr(ppc_pkg::OFS_DIR, dir);
      wr(i[0] ? ppc_pkg::OFS_PORT : ppc_pkg::OFS_LAT, lat);
      wr(ppc_pkg::OFS_ODC, odc);
      wr(ppc_pkg::OFS_ANS, ans);
      wr(3'h7, ~dir);
      repeat (4) @(posedge clk_i);
      #1;
      oe = oe_exp();
      lvl = lvl_exp();
      chk("pin_oe", oe, pin_oe_o);
      chk("pin_o", oe & lat, pin_o & pin_oe_o);
      chk("digital_in", lvl & ~ans, digital_in_o);
      chk("analog_en", ans, analog_en_o);
      rd(ppc_pkg::OFS_PORT, lvl & ~(ans & dir), "port");
      rd(ppc_pkg::OFS_LAT, lat, "latch");
      rd(ppc_pkg::OFS_DIR, dir, "dir");
      rd(ppc_pkg::OFS_ODC, odc, "odc");
      rd(ppc_pkg::OFS_ANS, ans, "ans");
    end
    $display("test random done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ppc_pkg::OFS_ANS, 16'hFFFF, "ans");
    rd(ppc_pkg::OFS_DIR, 16'hFFFF, "dir");
    rd(ppc_pkg::OFS_LAT, 16'h0000, "latch");
    rd(ppc_pkg::OFS_ODC, 16'h0000, "odc");
    rd(ppc_pkg::OFS_PORT, 16'h0000, "port");
    chk("pin_oe", 16'h0000, pin_oe_o);
    $display("test second reset done");
    results();
  end
endmodule // ppc_port_test
